// ===== bench/epv_dev_model.sv
/*
 behavioural program store device: code array, table, security bits, signature.
 assumes port 0 pull-ups are modelled by whoever resolves the wire.
*/
`timescale 1ns/1ps

module epv_dev_model #(
	// arbitrary signature values
	parameter logic [7:0] SIG0 = 8'hA5,
	parameter logic [7:0] SIG1 = 8'h3C
) (
	input wire logic dev_reset,
	input wire logic program_store_enable_n,
	input wire logic program_strobe_n,
	input wire logic program_strobe_n_supply_on,
	input wire logic [7:0] port1_out,
	input wire logic [7:0] port2_out,
	input wire logic port3_bit7,
	input wire logic port3_bit6,
	input wire logic [7:0] port0_in,
	output logic [7:0] dev_data,
	output logic dev_oe
);
	logic [7:0] code [0:16383];
	logic [7:0] enc [0:31];
	logic sec1 = 0;
	logic sec2 = 0;
	int n;
	wire [13:0] a = {port2_out[5:0], port1_out};
	wire [3:0] lv = {port2_out[7:6], port3_bit7, port3_bit6};
	initial begin
		foreach (code[i]) code[i] = 8'hFF;
		foreach (enc[i]) enc[i] = 8'hFF;
	end
	////////////////////////////////////////////////////////////////
	// a location is written on the 25th pulse at programming supply
	always @(posedge program_strobe_n or negedge dev_reset) begin
		if (!dev_reset) begin
			n = 0;
		end else if (program_strobe_n_supply_on) begin
			n++;
			if (n == 25) begin
				case (lv)
					4'hB: if (!sec1 && !sec2) code[a] = port0_in;
					4'hA: if (!sec1 && !sec2) enc[a[4:0]] = port0_in;
					4'hF: sec1 = 1;
					4'hC: sec2 = 1;
					default: ;
				endcase
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// the table reaches the pins only XNORed with the code byte
	always @* begin
		dev_oe = dev_reset && !program_store_enable_n && program_strobe_n && lv[3:2] == 2'b00
			&& (lv[1:0] == 2'b00 || !sec2);
		dev_data = (lv[1:0] == 2'b00) ? (a[0] ? SIG1 : SIG0)
			: ~(code[a] ^ enc[a[4:0]]);
	end
endmodule

// ===== bench/epv_host_bench.sv
/*
 self-checking bench for the program/verify controller with a device model.
 assumes a 100 MHz core_clk and the command port offsets of epv_cfg.svh.
*/
`timescale 1ns/1ps
`include "epv_cfg.svh"

module epv_host_bench
	import epv_pkg::*;
;
	logic core_clk = 0;
	logic nrst = 0;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic [3:0] reg_addr = 0;
	logic [31:0] reg_wdata = 0;
	logic [31:0] reg_rdata;
	logic dev_reset, program_store_enable_n, program_strobe_n, program_strobe_n_supply_on;
	logic port3_bit7, port3_bit6, port0_oe, dev_oe;
	logic [7:0] port1_out, port2_out, port0_out, dev_data;
	int errors = 0;
	int cmp_count = 0;
	// pull-ups hold port 0 high when nobody drives it
	wire logic [7:0] port0_in = port0_oe ? port0_out : dev_oe ? dev_data : 8'hFF;
	epv_host u_epv_host (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.dev_osc(), .dev_reset(dev_reset), .program_store_enable_n(program_store_enable_n),
		.program_strobe_n(program_strobe_n), .program_strobe_n_supply_on(program_strobe_n_supply_on),
		.port1_out(port1_out), .port2_out(port2_out), .port3_bit7(port3_bit7),
		.port3_bit6(port3_bit6), .port0_out(port0_out), .port0_oe(port0_oe), .port0_in(port0_in));
	epv_dev_model #(.SIG0(8'hA5), .SIG1(8'h3C)) u_epv_dev_model (.dev_reset(dev_reset),
		.program_store_enable_n(program_store_enable_n), .program_strobe_n(program_strobe_n),
		.program_strobe_n_supply_on(program_strobe_n_supply_on), .port1_out(port1_out), .port2_out(port2_out),
		.port3_bit7(port3_bit7), .port3_bit6(port3_bit6), .port0_in(port0_in),
		.dev_data(dev_data), .dev_oe(dev_oe));
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////
	task report_and_stop;
		if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge core_clk);
		reg_wr <= 0;
	endtask
	task rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge core_clk);
		reg_rd <= 0;
		#1 d = reg_rdata;
	endtask
	// start one operation, wait for done, return the read byte register
	task op(input epv_op_e o, input logic [15:0] a, input logic [7:0] d, output logic [31:0] v);
		logic [31:0] s;
		int i;
		wr(`EPV_REG_ADDR, {16'h0, a});
		wr(`EPV_REG_DATA, {24'h0, d});
		wr(`EPV_REG_CTRL, {28'h000_0000, 1'b1, o});
		s = 0;
		for (i = 0; i < 200000 && s[`EPV_STAT_DONE] !== 1'b1; i++) rd(`EPV_REG_STATUS, s);
		chk("op done", {31'h0, s[`EPV_STAT_DONE]}, 32'h1);
		rd(`EPV_REG_RDATA, v);
	endtask
	////////////////////////////////////////////////////////////////
	task t_code;
		logic [31:0] v;
		op(EPV_OP_PROGRAM_STROBE_N, 16'h0105, 8'h5A, v);
		op(EPV_OP_VERIFY, 16'h0105, 8'h00, v);
		chk("verify written", v, 32'h5A);
		op(EPV_OP_VERIFY, 16'h0106, 8'h00, v);
		chk("verify erased", v, 32'hFF);
		rd(4'hF, v);
		chk("unmapped read", v, 32'h0);
	endtask
	task t_sig;
		logic [31:0] v;
		op(EPV_OP_SIG, `EPV_SIG_ADDR0, 8'h00, v);
		chk("signature 0", v, 32'hA5);
		op(EPV_OP_SIG, `EPV_SIG_ADDR1, 8'h00, v);
		chk("signature 1", v, 32'h3C);
	endtask
	task t_lock;
		logic [31:0] v;
		op(EPV_OP_SEC2, 16'h0000, 8'h00, v);
		op(EPV_OP_VERIFY, 16'h0105, 8'h00, v);
		chk("verify locked", v, 32'hFF);
	endtask
	initial begin
		repeat (10) @(posedge core_clk);
		nrst <= 1;
		repeat (3) @(posedge core_clk);
		t_code();
		t_sig();
		t_lock();
		report_and_stop();
	end
	initial begin
		repeat (1000000) @(posedge core_clk);
		errors++;
		report_and_stop();
	end
endmodule

// ===== bench/epv_host_properties.sv
/*
 port checker for the program/verify controller.
 assumes it is bound to epv_host and core_clk runs at 100 MHz.
*/
`timescale 1ns/1ps

module epv_host_properties (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic dev_osc,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic dev_reset,
	input wire logic program_store_enable_n,
	input wire logic program_strobe_n,
	input wire logic program_strobe_n_supply_on,
	input wire logic [7:0] port1_out,
	input wire logic [7:0] port2_out,
	input wire logic port3_bit7,
	input wire logic port3_bit6,
	input wire logic [7:0] port0_out,
	input wire logic port0_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	logic [31:0] lowc, hic, ac;
	logic [5:0] pc;
	logic [23:0] pv;
	wire [23:0] ad = {port2_out, port1_out, port0_out};
	wire [3:0] lv = {port2_out[7:6], port3_bit7, port3_bit6};
	////////////////////////////////////////////////////////////////
	// low time, high time, pin stability and pulse count
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			lowc <= 32'h0000_0000;
			// no pulse yet: counts as a long high time
			hic <= 32'h0000_FFFF;
			ac <= 32'h0000_0000;
			pc <= 6'h00;
			pv <= 24'h00_0000;
		end else begin
			lowc <= program_strobe_n ? 0 : lowc + 1;
			hic <= program_strobe_n ? hic + 1 : 0;
			pv <= ad;
			ac <= (ad != pv) ? 0 : ac + 1;
			pc <= !dev_reset ? 6'h00 : pc + 6'($fell(program_strobe_n));
		end
	end
	////////////////////////////////////////////////////////////////
	a_strobe_width: assert property ($rose(program_strobe_n) |-> lowc inside {[9000:11000]})
		else $error("strobe low time out of range");
	a_strobe_gap: assert property ($fell(program_strobe_n) |-> hic >= 1000)
		else $error("strobe high gap too short");
	a_addr_setup: assert property ($fell(program_strobe_n) |-> ac >= 960)
		else $error("address or data setup too short");
	a_addr_hold: assert property ($changed(ad) |-> program_strobe_n && hic >= 960)
		else $error("address or data hold too short");
	a_pulse_count: assert property ($fell(dev_reset) |-> pc == 25 || pc == 0)
		else $error("wrong number of strobe pulses");
	a_pulse_pins: assert property (!program_strobe_n |->
		program_strobe_n_supply_on && port0_oe && dev_reset && !program_store_enable_n)
		else $error("pins wrong during a pulse");
	a_verify_pins: assert property (dev_reset && !port2_out[7] |->
		program_strobe_n && !program_strobe_n_supply_on && !port0_oe)
		else $error("pins wrong during a read");
	a_mode_legal: assert property (dev_reset |->
		lv inside {4'hB, 4'h3, 4'h0, 4'hA, 4'hF, 4'hC})
		else $error("illegal mode levels");
	a_osc_half_min: assert property ($changed(dev_osc) |=> $stable(dev_osc) [*8])
		else $error("device oscillator half period too short");
	a_osc_half_max: assert property ($changed(dev_osc) |-> ##[1:12] $changed(dev_osc))
		else $error("device oscillator half period too long");
	a_rdata_slot: assert property (!$past(reg_rd) |-> reg_rdata == 0)
		else $error("read data outside its slot");
endmodule

bind epv_host epv_host_properties u_epv_host_properties (.core_clk, .nrst, .dev_osc, .reg_rd,
	.reg_rdata,
	.dev_reset, .program_store_enable_n, .program_strobe_n, .program_strobe_n_supply_on, .port1_out,
	.port2_out, .port3_bit7, .port3_bit6, .port0_out, .port0_oe);

// ===== logic/epv_cfg.svh
/*
 constants for the program/verify controller: timing counts, mode pin levels,
 register offsets of the controller's own command port.
 assumes core_clk at 100 MHz.
*/
`ifndef EPV_CFG_SVH
`define EPV_CFG_SVH

`define EPV_CLK_MHZ 100
// strobe low time in us, target 100, limits 90..110
`define EPV_PULSE_LOW_US 100
`define EPV_PULSE_LOW_CYC (`EPV_PULSE_LOW_US * `EPV_CLK_MHZ)
// high gap between strobes and supply setup/hold, least 10 us
`define EPV_GAP_US 10
`define EPV_GAP_CYC (`EPV_GAP_US * `EPV_CLK_MHZ)
// 48 osc periods at slowest 4 MHz = 12 us, rounded up
`define EPV_OSC_PERIODS 48
`define EPV_OSC_MIN_MHZ 4
`define EPV_SETUP_CYC ((`EPV_OSC_PERIODS * `EPV_CLK_MHZ + `EPV_OSC_MIN_MHZ - 1) / `EPV_OSC_MIN_MHZ)
`define EPV_PULSES 25
// osc divider: 100/20 = 5 MHz, inside 4..6 MHz
`define EPV_OSC_HALF 10
`define EPV_ENC_LAST 16'h001F
`define EPV_SIG_ADDR0 16'h0030
`define EPV_SIG_ADDR1 16'h0031

// command port offsets
`define EPV_REG_CTRL 4'h0
`define EPV_REG_ADDR 4'h1
`define EPV_REG_DATA 4'h2
`define EPV_REG_STATUS 4'h3
`define EPV_REG_RDATA 4'h4

// ctrl bits: [2:0] operation, [3] start
`define EPV_CTRL_START 3
`define EPV_STAT_BUSY 0
`define EPV_STAT_DONE 1

// mode pin levels {p27,p26,p37,p36}
`define EPV_LV_PROGRAM_STROBE_N 4'hB
`define EPV_LV_VERIFY 4'h3
`define EPV_LV_SIG 4'h0
`define EPV_LV_ENC 4'hA
`define EPV_LV_SEC1 4'hF
`define EPV_LV_SEC2 4'hC

`endif

// ===== logic/epv_host.sv
/*
 external programming controller for an on-chip program store: drives address,
 data, mode levels and the program strobe; reads back verify and signature data.
 assumes the device pins are wired directly, port 0 has external pull-ups,
 and the programming supply switch follows program_strobe_n_supply_on.
*/
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "epv_cfg.svh"

module epv_host
	import epv_pkg::*;
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic dev_osc,
	output logic dev_reset,
	output logic program_store_enable_n,
	output logic program_strobe_n,
	output logic program_strobe_n_supply_on,
	output logic [7:0] port1_out,
	output logic [7:0] port2_out,
	output logic port3_bit7,
	output logic port3_bit6,
	output logic [7:0] port0_out,
	output logic port0_oe,
	input wire logic [7:0] port0_in
);

	////////////////////////////////////////////////////////////////////////////
	// reset release and input synchronisers

	logic [1:0] rst_sync;
	logic rst_n;
	logic [7:0] p0_meta;
	logic [7:0] p0_sync;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			p0_meta <= 8'hFF;
			p0_sync <= 8'hFF;
		end else begin
			p0_meta <= port0_in;
			p0_sync <= p0_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// device oscillator, 5 MHz, runs from reset release onward

	logic [4:0] osc_div;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_div <= 5'h00;
			dev_osc <= 1'b0;
		end else if (osc_div == 5'(`EPV_OSC_HALF - 1)) begin
			osc_div <= 5'h00;
			dev_osc <= ~dev_osc;
		end else begin
			osc_div <= osc_div + 5'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// command registers

	epv_op_e op;
	logic [15:0] tgt_addr;
	logic [7:0] wr_byte;
	logic [7:0] rd_byte;
	logic busy;
	logic done;
	logic start;

	// op codes above the last defined one are refused
	assign start = reg_wr && reg_addr == `EPV_REG_CTRL && reg_wdata[`EPV_CTRL_START] && !busy &&
		reg_wdata[2:0] <= EPV_OP_SEC2;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			op <= EPV_OP_VERIFY;
			tgt_addr <= 16'h0000;
			wr_byte <= 8'hFF;
		end else if (reg_wr && !busy) begin
			if (reg_addr == `EPV_REG_CTRL) begin
				op <= epv_op_e'(reg_wdata[2:0]);
			end
			if (reg_addr == `EPV_REG_ADDR) begin
				tgt_addr <= reg_wdata[15:0];
			end
			if (reg_addr == `EPV_REG_DATA) begin
				wr_byte <= reg_wdata[7:0];
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`EPV_REG_CTRL: reg_rdata <= {29'h0, op};
				`EPV_REG_ADDR: reg_rdata <= {16'h0, tgt_addr};
				`EPV_REG_DATA: reg_rdata <= {24'h0, wr_byte};
				`EPV_REG_STATUS: reg_rdata <= {30'h0, done, busy};
				`EPV_REG_RDATA: reg_rdata <= {24'h0, rd_byte};
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer

	epv_state_e state;
	logic [15:0] timer;
	logic [4:0] pulses;
	logic writing;
	logic [3:0] levels;
	epv_op_e sel_op;

	// a start takes its levels from the op written in the same cycle
	assign sel_op = start ? epv_op_e'(reg_wdata[2:0]) : op;
	assign writing = sel_op != EPV_OP_VERIFY && sel_op != EPV_OP_SIG;
	assign busy = state != EPV_ST_IDLE;

	always_comb begin
		unique case (sel_op)
			EPV_OP_PROGRAM_STROBE_N: levels = `EPV_LV_PROGRAM_STROBE_N;
			EPV_OP_VERIFY: levels = `EPV_LV_VERIFY;
			EPV_OP_SIG: levels = `EPV_LV_SIG;
			EPV_OP_ENC: levels = `EPV_LV_ENC;
			EPV_OP_SEC1: levels = `EPV_LV_SEC1;
			EPV_OP_SEC2: levels = `EPV_LV_SEC2;
			default: levels = `EPV_LV_VERIFY;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= EPV_ST_IDLE;
			timer <= 16'h0000;
		end else begin
			unique case (state)
				EPV_ST_IDLE: begin
					if (start) begin
						state <= EPV_ST_SETUP;
						timer <= 16'h0000;
					end
				end
				EPV_ST_SETUP: begin
					// setup covers 48 osc periods and supply settle
					timer <= timer + 16'h0001;
					if (!writing && timer == 16'(`EPV_SETUP_CYC - 1)) begin
						state <= EPV_ST_READ;
					end else if (writing && timer == 16'(`EPV_SETUP_CYC - 1)) begin
						state <= EPV_ST_LOW;
						timer <= 16'h0000;
					end
				end
				EPV_ST_LOW: begin
					timer <= timer + 16'h0001;
					if (timer == 16'(`EPV_PULSE_LOW_CYC - 1)) begin
						state <= EPV_ST_HIGH;
						timer <= 16'h0000;
					end
				end
				EPV_ST_HIGH: begin
					timer <= timer + 16'h0001;
					if (timer == 16'(`EPV_SETUP_CYC - 1)) begin
						timer <= 16'h0000;
						if (pulses == 5'(`EPV_PULSES)) begin
							state <= EPV_ST_HOLD;
						end else begin
							state <= EPV_ST_LOW;
						end
					end
				end
				EPV_ST_HOLD: begin
					// hold after last strobe before modes drop
					timer <= timer + 16'h0001;
					if (timer == 16'(`EPV_SETUP_CYC - 1)) begin
						state <= EPV_ST_IDLE;
					end
				end
				EPV_ST_READ: begin
					state <= EPV_ST_IDLE;
				end
				default: state <= EPV_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pulses <= 5'h00;
		end else if (start) begin
			pulses <= 5'h00;
		end else if (state == EPV_ST_LOW && timer == 16'(`EPV_PULSE_LOW_CYC - 1)) begin
			pulses <= pulses + 5'h01;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			done <= 1'b0;
		end else if (start) begin
			done <= 1'b0;
		end else if ((state == EPV_ST_HOLD && timer == 16'(`EPV_SETUP_CYC - 1)) ||
				state == EPV_ST_READ) begin
			done <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_byte <= 8'hFF;
		end else if (state == EPV_ST_READ) begin
			rd_byte <= p0_sync;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pins

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dev_reset <= 1'b0;
			program_store_enable_n <= 1'b1;
			program_strobe_n <= 1'b1;
			program_strobe_n_supply_on <= 1'b0;
		end else begin
			dev_reset <= busy || start;
			program_store_enable_n <= !(busy || start);
			program_strobe_n <= !(state == EPV_ST_LOW);
			// supply up for setup through hold, gaps exceed 10 us
			program_strobe_n_supply_on <= writing && (busy || start);
		end
	end

	// address and mode levels stand for the whole operation
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			port1_out <= 8'h00;
			port2_out <= 8'h00;
			port3_bit7 <= 1'b1;
			port3_bit6 <= 1'b1;
		end else if (start) begin
			port1_out <= tgt_addr[7:0];
			port2_out <= {levels[3:2], tgt_addr[13:8]};
			port3_bit7 <= levels[1];
			port3_bit6 <= levels[0];
		end else if (!busy) begin
			port2_out[7:6] <= 2'b00;
		end
	end

	// port 0 is driven only for writes; reads lean on the pull-ups
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			port0_out <= 8'hFF;
			port0_oe <= 1'b0;
		end else if (start) begin
			port0_out <= wr_byte;
			port0_oe <= writing;
		end else if (!busy) begin
			port0_oe <= 1'b0;
		end
	end

endmodule

// ===== logic/epv_pkg.sv
/*
 types for the program/verify controller.
 assumes epv_cfg.svh is seen first where constants are needed.
*/
package epv_pkg;
	typedef enum logic [2:0] {
		EPV_OP_PROGRAM_STROBE_N = 3'b000,
		EPV_OP_VERIFY = 3'b001,
		EPV_OP_SIG = 3'b010,
		EPV_OP_ENC = 3'b011,
		EPV_OP_SEC1 = 3'b100,
		EPV_OP_SEC2 = 3'b101
	} epv_op_e;

	typedef enum logic [2:0] {
		EPV_ST_IDLE = 3'b000,
		EPV_ST_SETUP = 3'b001,
		EPV_ST_LOW = 3'b010,
		EPV_ST_HIGH = 3'b011,
		EPV_ST_HOLD = 3'b100,
		EPV_ST_READ = 3'b101
	} epv_state_e;
endpackage
